// ===== hdl/vpwfl_link.v
`timescale 1ns/10ps
`include "vpwfl_defines.vh"
// Overview of operation
// R1 - Frames carry at most twelve bytes; longer received frames get flagged.
// R2 - Bytes travel most significant bit first.
// R3 - Frame order: idle, start, data, CRC, end of data, normalization, response, end, gap.
// R4 - Bus idles low; idle once the inter-frame gap has elapsed.
// R5 - Start of frame is a high pulse of about 200 us.
// R6 - CRC covers bits after start of frame, never the start pulse.
// R7 - CRC accumulator is preset to all ones before each frame.
// R8 - A mismatching received CRC raises a CRC error flag; only the data part's CRC is checked, a response CRC is not.
// R9 - End of data is a low period of about 200 us.
// R10 - Without response, the bus stays low until end of frame qualifies.
// R11 - Normalization pulse of 64 or 128 us opens a response and marks CRC.
// R12 - Response bytes come from the frame receiver after normalization.
// R13 - Low for end-of-frame time during response completes the frame.
// R14 - End of frame is a low period of about 280 us.
// R15 - A break anywhere abandons the frame in progress.
// R16 - Inter-frame separation must elapse before a new frame starts.
// R17 - Quad speed shortens all symbol durations by four.
// R18 - Loopback returns host transmit data on the receive line.
// R19 - Symbols timed by a microsecond tick within a tolerance window.
// R20 - CRC is eight bits, customary polynomial, sent inverted.
// R21 - Frame status reports CRC error, overlength, break and response at end.
module vpwfl_link (
  input wire i_clk,
  input wire i_resetn,
  input wire i_bus_rx,
  input wire i_tx,
  input wire i_quad_speed_select,
  input wire i_loopback,
  output reg o_rx,
  output reg o_bus_tx,
  output reg o_byte_valid,
  output reg [7:0] o_byte,
  output reg o_byte_in_ifr,
  output reg o_frame_done,
  output reg o_crc_err,
  output reg o_overlength,
  output reg o_break,
  output reg o_ifr_seen,
  output reg o_ifr_long_nb,
  output reg o_bus_idle
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DATA = 3'd1;
  localparam ST_EOD = 3'd2;
  localparam ST_IFR = 3'd3;
  localparam ST_IFS = 3'd4;
  localparam ST_WAIT = 3'd5;

  reg [1:0] rst_sync_reg;
  wire rst;
  reg [5:0] div_reg;
  reg us_tick_reg;
  reg [11:0] len_reg;
  reg bus_reg;
  reg [2:0] state_reg;
  reg [7:0] sh_reg;
  reg [2:0] bit_cnt_reg;
  reg [3:0] byte_cnt_reg;
  reg [7:0] last_byte_reg;
  reg [7:0] crc_before_reg;
  reg crc_bad_reg;
  reg nb_reg;
  reg bit_valid;
  reg bit_val;
  reg crc_init;
  wire [7:0] crc_now;
  wire [11:0] len_s;
  wire edge_seen;
  wire [11:0] t_sof;
  wire [11:0] t_nbl;
  wire [11:0] t_split;
  wire [11:0] t_eod;
  wire [11:0] t_eof;
  wire [11:0] t_ifs;
  wire [11:0] t_brk;
  wire [11:0] t_tol;

  // Reset release through two flip-flops.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst = ~rst_sync_reg[1];

  // Scale each nominal time by four in quad speed mode.
  assign t_sof = i_quad_speed_select ? 12'd`VPWFL_T_SOF_US >> 2 : 12'd`VPWFL_T_SOF_US; // [R17]
  assign t_nbl = i_quad_speed_select ? 12'd`VPWFL_T_NB_LONG_US >> 2 : 12'd`VPWFL_T_NB_LONG_US;
  assign t_split = i_quad_speed_select ? 12'd`VPWFL_T_BITSPLIT_US >> 2 :
    12'd`VPWFL_T_BITSPLIT_US;
  assign t_eod = i_quad_speed_select ? 12'd`VPWFL_T_EOD_US >> 2 : 12'd`VPWFL_T_EOD_US;
  assign t_eof = i_quad_speed_select ? 12'd`VPWFL_T_EOF_US >> 2 : 12'd`VPWFL_T_EOF_US;
  assign t_ifs = i_quad_speed_select ? 12'd`VPWFL_T_IFS_US >> 2 : 12'd`VPWFL_T_IFS_US;
  assign t_brk = i_quad_speed_select ? 12'd`VPWFL_T_BRK_US >> 2 : 12'd`VPWFL_T_BRK_US;
  assign t_tol = i_quad_speed_select ? 12'd`VPWFL_TOL_US >> 2 : 12'd`VPWFL_TOL_US;

  // Microsecond tick from the system clock.
  always @(posedge i_clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= 6'h00;
      us_tick_reg <= 1'b0;
    end
    else if (div_reg == 6'd`VPWFL_TICK_DIV - 6'd1)
    begin
      div_reg <= 6'h00;
      us_tick_reg <= 1'b1; // [R19]
    end
    else
    begin
      div_reg <= div_reg + 6'd1;
      us_tick_reg <= 1'b0;
    end
  end

  assign edge_seen = (i_bus_rx != bus_reg);
  assign len_s = len_reg;

  vpwfl_crc8 u_crc (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_init(crc_init),
    .i_bit_valid(bit_valid),
    .i_bit(bit_val),
    .o_crc(crc_now)
  );

  // Classify each completed pulse of the data or response part, other than the normalization bit, into a data bit.
  always @*
  begin
    bit_valid = 1'b0;
    bit_val = 1'b0;
    crc_init = 1'b0;
    if (edge_seen && bus_reg && state_reg == ST_IDLE && len_s + t_tol >= t_sof)
      crc_init = 1'b1; // [R6] [R7]
    if (edge_seen && (state_reg == ST_DATA || state_reg == ST_IFR) && !nb_reg &&
      len_s < t_sof - t_tol)
    begin
      bit_valid = 1'b1;
      // Long low is 1, long high is 0: passive and active symbols.
      bit_val = (len_s >= t_split) ^ bus_reg;
    end
  end

  // Frame receive engine and pulse width measurement.
  always @(posedge i_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_reg <= 1'b0;
      len_reg <= 12'h000;
      state_reg <= ST_IDLE;
      sh_reg <= 8'h00;
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 4'd0;
      last_byte_reg <= 8'h00;
      crc_before_reg <= 8'hFF;
      crc_bad_reg <= 1'b0;
      nb_reg <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte <= 8'h00;
      o_byte_in_ifr <= 1'b0;
      o_frame_done <= 1'b0;
      o_crc_err <= 1'b0;
      o_overlength <= 1'b0;
      o_break <= 1'b0;
      o_ifr_seen <= 1'b0;
      o_ifr_long_nb <= 1'b0;
      o_bus_idle <= 1'b0;
    end
    else
    begin
      bus_reg <= i_bus_rx;
      o_byte_valid <= 1'b0;
      o_frame_done <= 1'b0;
      if (edge_seen)
        len_reg <= 12'h000;
      else if (us_tick_reg && len_reg != 12'hFFF)
        len_reg <= len_reg + 12'd1;
      // A long high in any state but ST_WAIT is a break; drop the frame.
      if (bus_reg && len_s >= t_brk && state_reg != ST_WAIT)
      begin
        o_break <= 1'b1; // [R15]
        o_frame_done <= 1'b1; // [R21]
        o_bus_idle <= 1'b0;
        state_reg <= ST_WAIT;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            o_bus_idle <= ~bus_reg; // [R4]
            if (edge_seen && bus_reg && len_s + t_tol >= t_sof)
            begin
              state_reg <= ST_DATA; // [R5] [R3]
              bit_cnt_reg <= 3'd0;
              byte_cnt_reg <= 4'd0;
              o_crc_err <= 1'b0;
              o_overlength <= 1'b0;
              o_break <= 1'b0;
              o_ifr_seen <= 1'b0;
              o_ifr_long_nb <= 1'b0;
              o_byte_in_ifr <= 1'b0;
              o_bus_idle <= 1'b0;
              nb_reg <= 1'b0;
            end
          end
          ST_DATA, ST_IFR:
          begin
            if (bit_valid)
            begin
              sh_reg <= {sh_reg[6:0], bit_val}; // [R2]
              bit_cnt_reg <= bit_cnt_reg + 3'd1;
              if (bit_cnt_reg == 3'd0)
                crc_before_reg <= crc_now; // CRC over all earlier bytes.
              if (bit_cnt_reg == 3'd7)
              begin
                o_byte <= {sh_reg[6:0], bit_val};
                o_byte_valid <= 1'b1;
                o_byte_in_ifr <= (state_reg == ST_IFR); // [R12]
                last_byte_reg <= {sh_reg[6:0], bit_val};
                if (byte_cnt_reg == 4'd`VPWFL_MAX_BYTES)
                  o_overlength <= 1'b1; // [R1]
                else
                  byte_cnt_reg <= byte_cnt_reg + 4'd1;
              end
            end
            // Long low ends the data part or the response part.
            if (!bus_reg && state_reg == ST_DATA && len_s >= t_eod - t_tol)
            begin
              state_reg <= ST_EOD; // [R9]
              // Last byte must equal the inverted CRC of the earlier bytes; shown at frame end.
              crc_bad_reg <= (last_byte_reg != ~crc_before_reg); // [R8] [R20]
            end
            else if (!bus_reg && state_reg == ST_IFR && len_s >= t_eof - t_tol)
            begin
              state_reg <= ST_IFS; // [R13]
              o_frame_done <= 1'b1;
              o_crc_err <= crc_bad_reg; // [R21]
            end
          end
          ST_EOD:
          begin
            if (edge_seen && !bus_reg)
            begin
              // Rising edge after end of data is a normalization bit.
              state_reg <= ST_IFR; // [R11]
              bit_cnt_reg <= 3'd0;
              o_ifr_seen <= 1'b1;
              nb_reg <= 1'b1;
            end
            else if (!bus_reg && len_s >= t_eof - t_tol)
            begin
              state_reg <= ST_IFS; // [R10] [R14]
              o_frame_done <= 1'b1; // [R21]
              o_crc_err <= crc_bad_reg; // [R8]
            end
          end
          ST_IFS, ST_WAIT:
          begin
            // Gap must pass with the bus low before idling again.
            if (!bus_reg && len_s >= t_ifs)
              state_reg <= ST_IDLE; // [R16]
          end
          default:
            state_reg <= ST_IDLE;
        endcase
        // The first falling edge of the response part ends the normalization bit.
        if (state_reg == ST_IFR && nb_reg && edge_seen && bus_reg)
        begin
          nb_reg <= 1'b0;
          o_ifr_long_nb <= (len_s + t_tol >= t_nbl); // [R11]
        end
      end
    end
  end

  // Transmit path and host receive line, with optional loopback.
  always @(posedge i_clk or posedge rst)
  begin
    if (rst)
    begin
      o_bus_tx <= 1'b0;
      o_rx <= 1'b0;
    end
    else
    begin
      o_bus_tx <= i_tx;
      o_rx <= i_loopback ? i_tx : i_bus_rx; // [R18]
    end
  end
endmodule // vpwfl_link

// ===== hdl/vpwfl_defines.vh
`ifndef VPWFL_DEFINES_VH
`define VPWFL_DEFINES_VH
// Microsecond tick: 40 MHz clock gives 40 cycles per microsecond.
`define VPWFL_CLK_MHZ 40
`define VPWFL_TICK_DIV `VPWFL_CLK_MHZ
// Nominal symbol times in microseconds at normal speed.
`define VPWFL_T_SOF_US 200
`define VPWFL_T_EOD_US 200
`define VPWFL_T_NB_SHORT_US 64
`define VPWFL_T_NB_LONG_US 128
`define VPWFL_T_EOF_US 280
`define VPWFL_T_IFS_US 300
`define VPWFL_T_BRK_US 600
`define VPWFL_T_BIT0_US 64
`define VPWFL_T_BIT1_US 128
// Bit boundary between short and long data symbols.
`define VPWFL_T_BITSPLIT_US 96
// Acceptance tolerance for a symbol, in microseconds.
`define VPWFL_TOL_US 24
`define VPWFL_MAX_BYTES 12
`define VPWFL_CRC_INIT 8'hFF
`define VPWFL_CRC_POLY 8'h1D
`endif

// ===== hdl/vpwfl_crc8.v
`timescale 1ns/10ps
`include "vpwfl_defines.vh"
// Serial CRC-8 accumulator, one bit per strobe, most significant bit first.
module vpwfl_crc8 (
  input wire i_clk,
  input wire i_rst,
  input wire i_init,
  input wire i_bit_valid,
  input wire i_bit,
  output wire [7:0] o_crc
);
  reg [7:0] crc_reg;
  wire fb;
  assign fb = crc_reg[7] ^ i_bit;
  assign o_crc = crc_reg;
  // Preset to all ones, then shift in each bit.
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      crc_reg <= `VPWFL_CRC_INIT;
    else if (i_init)
      crc_reg <= `VPWFL_CRC_INIT; // [R7]
    else if (i_bit_valid)
      crc_reg <= {crc_reg[6:0], 1'b0} ^ (fb ? `VPWFL_CRC_POLY : 8'h00); // [R20]
  end
endmodule // vpwfl_crc8

// ===== verif/vpwfl_link_asserts.sv
`timescale 1ns/10ps
// Watches the link ports for timing relations that must always hold.
module vpwfl_link_asserts (
  input wire i_clk,
  input wire i_resetn,
  input wire i_bus_rx,
  input wire i_tx,
  input wire i_loopback,
  input wire o_rx,
  input wire o_bus_tx,
  input wire o_byte_valid,
  input wire o_frame_done,
  input wire o_crc_err,
  input wire o_overlength,
  input wire o_break,
  input wire o_ifr_seen,
  input wire o_ifr_long_nb,
  input wire o_bus_idle
);
  reg [2:0] up_reg;
  reg [3:0] hi_reg;
  reg done_reg;
  wire ok = (up_reg == 3'h5);

  // Counts edges after reset release and keeps short bus and done histories.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      up_reg <= 3'h0;
      hi_reg <= 4'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      if (up_reg != 3'h5)
        up_reg <= up_reg + 3'h1;
      hi_reg <= {hi_reg[2:0], i_bus_rx};
      done_reg <= o_frame_done;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_loop_echo: assert property (
    ok && $past(i_loopback) |-> o_rx == $past(i_tx)) else $error("loop echo wrong");
  a_rx_from_bus: assert property (
    ok && !$past(i_loopback) |-> o_rx == $past(i_bus_rx)) else $error("rx not bus");
  a_tx_copy: assert property (
    ok |-> o_bus_tx == $past(i_tx)) else $error("bus tx not copied");
  a_byte_pulse: assert property (
    o_byte_valid |=> !o_byte_valid) else $error("byte valid too long");
  a_done_pulse: assert property (
    o_frame_done |=> !o_frame_done) else $error("frame done too long");
  a_flags_hold: assert property (
    ok && $changed({o_crc_err, o_overlength, o_ifr_seen, o_ifr_long_nb})
    |-> o_frame_done || done_reg || (|hi_reg)) else $error("flag moved");
  a_idle_low: assert property (
    o_bus_idle |-> !$past(i_bus_rx, 2)) else $error("idle with bus high");
  a_idle_drop: assert property (
    ok && i_bus_rx [*8] |-> !o_bus_idle) else $error("idle kept");
  a_byte_busy: assert property (
    o_byte_valid |-> !o_bus_idle) else $error("byte while idle");
  a_break_done: assert property (
    $rose(o_break) |-> o_frame_done) else $error("break no done");
endmodule // vpwfl_link_asserts

bind vpwfl_link vpwfl_link_asserts u_vpwfl_link_asserts (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_bus_rx(i_bus_rx), .i_tx(i_tx), .i_loopback(i_loopback), .o_rx(o_rx),
  .o_bus_tx(o_bus_tx), .o_byte_valid(o_byte_valid), .o_frame_done(o_frame_done),
  .o_crc_err(o_crc_err), .o_overlength(o_overlength), .o_break(o_break),
  .o_ifr_seen(o_ifr_seen), .o_ifr_long_nb(o_ifr_long_nb), .o_bus_idle(o_bus_idle));

// ===== verif/vpwfl_node_model.sv
`timescale 1ns/10ps
// Remote node on the wire; all widths are quad-speed microseconds.
module vpwfl_node_model (
  input wire i_clk,
  output logic o_bus
);
  logic lvl = 1'b0;

  initial o_bus = 1'b0;

  // Holds the wire at one level for a number of microseconds.
  task sym(input logic v, input int us);
    o_bus <= v;
    repeat (us * 40) @(posedge i_clk);
  endtask

  // Sends a byte MSB first; each bit flips the level and is long when value differs.
  task put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      lvl = ~lvl;
      sym(lvl, (b[i] != lvl) ? 32 : 16);
    end
  endtask

  // Sends start, bytes, optional response, then end of frame and the gap.
  task frame(input logic [7:0] d[$], input int nb, input logic [7:0] r[$]);
    @(posedge i_clk);
    sym(1'b1, 50);
    lvl = 1'b1;
    foreach (d[k]) put(d[k]);
    if (nb > 0)
    begin
      sym(1'b0, 50);
      sym(1'b1, nb);
      lvl = 1'b1;
      foreach (r[k]) put(r[k]);
    end
    sym(1'b0, 85);
  endtask

  // Starts a frame and cuts it with a long high level.
  task brk;
    @(posedge i_clk);
    sym(1'b1, 50);
    sym(1'b0, 16);
    sym(1'b1, 160);
    sym(1'b0, 85);
  endtask
endmodule // vpwfl_node_model

// ===== verif/vpw_frame_link_bench.sv
`timescale 1ns/10ps
// Drives the link from a node model and checks bytes, flags and echo.
module vpw_frame_link_bench;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_tx = 1'b0;
  logic i_loopback = 1'b0;
  logic quad = 1'b1;
  wire bus;
  wire o_rx, o_bus_tx, o_byte_valid, o_byte_in_ifr, o_frame_done, o_crc_err;
  wire o_overlength, o_break, o_ifr_seen, o_ifr_long_nb, o_bus_idle;
  wire [7:0] o_byte;
  int bad_count = 0;
  int checks = 0;
  int dones = 0;
  logic [7:0] rq[$];
  logic iq[$];

  always #12.5 i_clk = ~i_clk;

  vpwfl_node_model u_vpwfl_node_model (.i_clk(i_clk), .o_bus(bus));
  vpwfl_link u_vpwfl_link (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus_rx(bus), .i_tx(i_tx),
    .i_quad_speed_select(quad), .i_loopback(i_loopback), .o_rx(o_rx), .o_bus_tx(o_bus_tx),
    .o_byte_valid(o_byte_valid), .o_byte(o_byte), .o_byte_in_ifr(o_byte_in_ifr),
    .o_frame_done(o_frame_done), .o_crc_err(o_crc_err), .o_overlength(o_overlength),
    .o_break(o_break), .o_ifr_seen(o_ifr_seen), .o_ifr_long_nb(o_ifr_long_nb),
    .o_bus_idle(o_bus_idle));

  // Collects received bytes and counts frame completions.
  always @(posedge i_clk)
  begin
    if (o_byte_valid === 1'b1)
    begin
      rq.push_back(o_byte);
      iq.push_back(o_byte_in_ifr);
    end
    if (o_frame_done === 1'b1)
      dones++;
  end

  // Inverted CRC-8, preset to ones, MSB first.
  function automatic logic [7:0] crc_of(input logic [7:0] d[$]);
    logic [7:0] c;
    c = 8'hFF;
    foreach (d[k])
      for (int i = 7; i >= 0; i--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k][i]) ? 8'h1D : 8'h00);
    return ~c;
  endfunction

  // Compares one value and reports a difference at once.
  task cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Echo with loopback on, bus level with it off.
  task t_loop;
    i_loopback <= 1'b1;
    repeat (2)
    begin
      @(posedge i_clk);
      i_tx <= ~i_tx;
      repeat (2) @(posedge i_clk);
      #1;
      cmp({7'h00, o_rx}, {7'h00, i_tx}, "loop echo");
      cmp({7'h00, o_bus_tx}, {7'h00, i_tx}, "tx copy");
    end
    @(posedge i_clk);
    i_loopback <= 1'b0;
    i_tx <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    cmp({7'h00, o_rx}, 8'h00, "rx not from bus");
    $display("test done: loopback");
  endtask

  // A start pulse of quad-speed length is too short to open a frame at normal speed.
  task t_speed;
    int n0;
    n0 = dones;
    @(posedge i_clk);
    quad <= 1'b0;
    u_vpwfl_node_model.sym(1'b1, 50);
    u_vpwfl_node_model.sym(1'b0, 20);
    #1;
    cmp(8'(dones - n0), 8'h00, "slow done");
    cmp({7'h00, o_bus_idle}, 8'h01, "slow idle");
    @(posedge i_clk);
    quad <= 1'b1;
    $display("test done: normal speed");
  endtask

  // Sends one frame, then checks bytes, flags and idle.
  task run(input logic [7:0] d[$], input int nb, input logic [7:0] r[$], input logic e);
    int n0;
    logic [7:0] x[$];
    n0 = dones;
    x = {d, r};
    rq.delete();
    iq.delete();
    u_vpwfl_node_model.frame(d, nb, r);
    #1;
    cmp(8'(dones - n0), 8'h01, "done count");
    cmp(8'(rq.size()), 8'(x.size()), "byte count");
    foreach (x[k]) cmp(rq[k], x[k], "byte");
    foreach (x[k]) cmp({7'h00, iq[k]}, {7'h00, k >= d.size()}, "ifr mark");
    cmp({7'h00, o_crc_err}, {7'h00, e}, "crc flag");
    cmp({7'h00, o_ifr_seen}, {7'h00, nb > 0}, "ifr flag");
    cmp({7'h00, o_ifr_long_nb}, {7'h00, nb == 32}, "nb width");
    cmp({6'h00, o_overlength, o_break}, 8'h00, "stray flag");
    cmp({7'h00, o_bus_idle}, 8'h01, "idle");
    $display("test done: frame of %0d bytes", x.size());
  endtask

  // A break in mid-frame ends it and raises the break flag.
  task t_break;
    int n0;
    n0 = dones;
    u_vpwfl_node_model.brk();
    #1;
    cmp(8'(dones - n0), 8'h01, "break done");
    cmp({7'h00, o_break}, 8'h01, "break flag");
    $display("test done: break");
  endtask

  // Main sequence.
  initial
  begin
    logic [7:0] a[$];
    logic [7:0] r[$];
    logic [7:0] z[$];
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_loop();
    t_speed();
    a = {8'h55};
    a.push_back(crc_of(a));
    run(a, 0, z, 1'b0);
    r = {8'h55};
    r.push_back(crc_of(r));
    run(a, 32, r, 1'b0);
    t_break();
    a[1] = a[1] ^ 8'h01;
    r = {8'h55};
    run(a, 16, r, 1'b1);
    wrap_up();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (100000) @(posedge i_clk);
    bad_count++;
    wrap_up();
  end
endmodule // vpw_frame_link_bench
